// ==== rtl/duh_top.sv ====
// converter update handshake control: input registers, busy, load and reset
module duh_top (
    // system clock and power-on reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // serial link
    input  wire logic        sclk,
    input  wire logic        csB,
    input  wire logic        din,
    output logic             dout,
    output logic             doutOe,
    output logic             readyB,
    // control pins
    input  wire logic        hwResetB,
    input  wire logic        loadOutputN,
    input  wire logic        levelSelect,
    input  wire logic        inputFormatSelect,
    input  wire logic        powerDownIn,
    // open-drain busy line
    input  wire logic        busyIn,
    output logic             busyOut,
    output logic             busyOe,
    // converter side
    output logic [17:0]      dacCode,
    output logic             outputClamped
);
    // crossing and pin sampling
    logic [23:0]         frameWord;     // last complete frame, link domain
    logic                frameToggle;   // flips once per complete frame
    logic [6:0]          pinSync;       // synchronised pins and toggle
    logic                hwRstS;        // hardware reset pin, high = run
    logic                loadS;         // load pin level
    logic                busyInS;       // busy line level
    logic                levelS;        // reset level select
    logic                fmtS;          // input format select
    logic                pdS;           // power-down pin
    logic                togS;          // frame toggle
    logic                togPrev;       // toggle one cycle ago
    logic                loadPrev;      // load pin one cycle ago

    // control state
    duh_pkg::duh_state_t state;         // current state
    duh_pkg::duh_state_t next_state;    // next state
    logic [7:0]          calcCnt;       // cycles into the calculation
    logic [7:0]          swRstCnt;      // software reset cycles left
    logic                loadPending;   // stored load request

    // registers
    logic [17:0]         dataReg;       // data input register, straight binary
    logic [17:0]         offsetReg;     // offset, signed
    logic [17:0]         gainReg;       // gain, 14 fraction bits
    logic [17:0]         calcReg;       // computed converter code

    // decoded events
    logic                frameEvent;    // a frame arrived this cycle
    logic [3:0]          frameCmd;      // its command
    logic [17:0]         frameVal;      // its value field
    logic [17:0]         inputWord;     // value in straight binary
    logic                writeCmd;      // frame writes an input register
    logic                swRstReq;      // frame asks for software reset
    logic                resetActive;   // any reset in force
    logic                lineBusy;      // busy seen low by us or others
    logic                loadFall;      // falling edge on the load pin
    logic                loadTake;      // converter code updates now
    logic [17:0]         defaultCode;   // reset output level
    logic                calcDone;      // last calculation cycle

    // busy is only ever pulled low, never driven high
    // open drain drive
    assign busyOut = 1'b0;

    // link-clock logic
    duh_link_rx u_link (
        .rstB        (rst_b),
        .sclk        (sclk),
        .csB         (csB),
        .din         (din),
        .frameWord   (frameWord),
        .frameToggle (frameToggle),
        .readyB      (readyB),
        .dout        (dout),
        .doutOe      (doutOe)
    );

    // every control pin, the busy line and the frame toggle pass two flops; the serial link pins do not
    duh_sync #(.WIDTH(7)) u_sync (
        .clk     (sys_clk),
        .rstB    (rst_b),
        .asyncIn ({frameToggle, powerDownIn, inputFormatSelect, levelSelect,
                   busyIn, loadOutputN, hwResetB}),
        .syncOut (pinSync)
    );

    assign hwRstS  = pinSync[0];
    assign loadS   = pinSync[1];
    assign busyInS = pinSync[2];
    assign levelS  = pinSync[3];
    assign fmtS    = pinSync[4];
    assign pdS     = pinSync[5];
    assign togS    = pinSync[6];

    // gain applied with the shifted product cut to 18 bits, then offset added with saturation to the code range
    function automatic logic [17:0] calc_code(input logic [17:0] data,
                                              input logic [17:0] gain,
                                              input logic [17:0] offset);
        logic [35:0]        prod;
        logic signed [20:0] sum;
        prod = data * gain;
        sum  = $signed({3'b000, prod[duh_pkg::GAIN_SHIFT +: 18]})
             + $signed({{3{offset[17]}}, offset});
        if (sum < 0) begin
            calc_code = duh_pkg::ZEROSCALE;
        end else if (sum > $signed({3'b000, duh_pkg::CODE_MAX})) begin
            calc_code = duh_pkg::CODE_MAX;
        end else begin
            calc_code = sum[17:0];
        end
    endfunction

    // edge history for the toggle and the load pin
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            togPrev  <= 1'b0;
            loadPrev <= 1'b0;
        end else begin
            togPrev  <= togS;
            loadPrev <= loadS;
        end
    end

    assign frameEvent = togS ^ togPrev;
    assign frameCmd   = frameWord[duh_pkg::CMD_MSB:duh_pkg::CMD_LSB];
    assign frameVal   = frameWord[duh_pkg::VAL_MSB:duh_pkg::VAL_LSB];
    assign writeCmd   = frameEvent && (frameCmd == duh_pkg::CMD_DATA ||
                        frameCmd == duh_pkg::CMD_OFFSET || frameCmd == duh_pkg::CMD_GAIN);
    assign swRstReq   = frameEvent && frameCmd == duh_pkg::CMD_SWRST;
    assign resetActive = (state == duh_pkg::ST_RESET);
    assign calcDone   = (state == duh_pkg::ST_CALC) && (calcCnt == duh_pkg::BUSY_CYCLES - 8'h01);
    assign loadFall   = loadPrev && !loadS;

    // two's complement words become straight binary by flipping the msb
    // input format
    assign inputWord  = fmtS ? (frameVal ^ duh_pkg::SIGN_BIT) : frameVal;

    assign defaultCode = levelS ? duh_pkg::MIDSCALE : duh_pkg::ZEROSCALE;

    // our own pull counts at once; the sampled line adds anyone else's
    // external busy honoured
    assign lineBusy = busyOe || !busyInS;

    assign loadTake = !resetActive && !lineBusy && (loadFall || loadPending);

    // state transitions; a new write during a calculation restarts it
    always_comb begin
        next_state = state;
        case (state)
            duh_pkg::ST_RESET: begin
                if (hwRstS && swRstCnt == 8'h00) begin
                    next_state = duh_pkg::ST_IDLE;
                end
            end
            duh_pkg::ST_IDLE: begin
                if (!hwRstS || swRstReq) begin
                    next_state = duh_pkg::ST_RESET;
                end else if (writeCmd) begin
                    next_state = duh_pkg::ST_CALC;
                end
            end
            duh_pkg::ST_CALC: begin
                if (!hwRstS || swRstReq) begin
                    next_state = duh_pkg::ST_RESET;
                end else if (calcDone && !writeCmd) begin
                    next_state = duh_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = duh_pkg::ST_RESET;
            end
        endcase
    end

    // state register and busy pull, both from the next state
    // busy during calculation
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state  <= duh_pkg::ST_RESET;
            busyOe <= 1'b1;
        end else begin
            state  <= next_state;
            busyOe <= (next_state != duh_pkg::ST_IDLE);
        end
    end

    // calculation cycle counter, restarted by every write
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            calcCnt <= 8'h00;
        end else if (state != duh_pkg::ST_CALC || writeCmd) begin
            calcCnt <= 8'h00;
        end else begin
            calcCnt <= calcCnt + 8'h01;
        end
    end

    // software reset length
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            swRstCnt <= 8'h00;
        end else if (swRstReq) begin
            swRstCnt <= duh_pkg::SWRST_CYCLES;
        end else if (swRstCnt != 8'h00) begin
            swRstCnt <= swRstCnt - 8'h01;
        end
    end

    // input registers: defaults in reset, frame writes at any other time
    // defaults in reset
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dataReg   <= duh_pkg::ZEROSCALE;
            offsetReg <= duh_pkg::OFFSET_DEF;
            gainReg   <= duh_pkg::GAIN_DEF;
        end else if (resetActive) begin
            dataReg   <= defaultCode;
            offsetReg <= duh_pkg::OFFSET_DEF;
            gainReg   <= duh_pkg::GAIN_DEF;
        end else if (frameEvent && frameCmd == duh_pkg::CMD_DATA) begin
            dataReg   <= inputWord;
        end else if (frameEvent && frameCmd == duh_pkg::CMD_OFFSET) begin
            offsetReg <= frameVal;
        end else if (frameEvent && frameCmd == duh_pkg::CMD_GAIN) begin
            gainReg   <= frameVal;
        end
    end

    // result latched at the end of the busy time, reset level while in reset
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            calcReg <= duh_pkg::ZEROSCALE;
        end else if (resetActive) begin
            calcReg <= defaultCode;
        end else if (calcDone && !writeCmd) begin
            calcReg <= calc_code(dataReg, gainReg, offsetReg);
        end
    end

    // a load seen while busy outside reset waits here; a take clears it, even in the cycle of a new fall
    // load latched
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            loadPending <= 1'b0;
        end else if (resetActive) begin
            loadPending <= 1'b0;
        end else if (loadFall && lineBusy) begin
            loadPending <= 1'b1;
        end else if (loadTake) begin
            loadPending <= 1'b0;
        end
    end

    // converter code: reset level until a load is taken
    // hold reset level
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dacCode <= duh_pkg::ZEROSCALE;
        end else if (resetActive) begin
            dacCode <= defaultCode;
        end else if (loadTake) begin
            dacCode <= calcReg;
        end
    end

    // power-down only clamps the output, registers are untouched
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            outputClamped <= 1'b0;
        end else begin
            outputClamped <= pdS;
        end
    end

    // checks on the system-clock logic
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence calc_start;
        state == duh_pkg::ST_IDLE && hwRstS && writeCmd && !swRstReq;
    endsequence

    a_reset_defaults: assert property (resetActive |=> dataReg == $past(defaultCode))
        else $error("input register not at reset default");
    a_hold_level: assert property (resetActive |=> dacCode == $past(defaultCode))
        else $error("converter code not at reset level");
    a_level_select: assert property (resetActive && levelS |=> calcReg == 18'h20000)
        else $error("midscale not chosen by level select");
    a_busy_calc: assert property (calc_start |=> busyOe[*8])
        else $error("busy not held through calculation");
    a_write_busy: assert property (state == duh_pkg::ST_CALC && !swRstReq && hwRstS
        && frameEvent && frameCmd == duh_pkg::CMD_DATA |=> dataReg == $past(inputWord))
        else $error("write lost while busy");
    a_frozen_busy: assert property (lineBusy && !resetActive |=> $stable(dacCode))
        else $error("converter code changed while busy");
    a_load_latch: assert property (loadFall && lineBusy && !resetActive |=> loadPending)
        else $error("load during busy lost");
    a_ext_busy: assert property (!busyInS && loadPending && !resetActive |=> loadPending)
        else $error("load acted while line held low");
    a_busy_reset: assert property (!hwRstS |=> busyOe && resetActive)
        else $error("busy not pulled in reset");
    a_load_idle: assert property (loadFall && !lineBusy && !resetActive
        |=> dacCode == $past(calcReg))
        else $error("idle load did not update code");
    a_load_ignore: assert property (resetActive |=> !loadPending)
        else $error("load kept during reset");
endmodule

// ==== rtl/duh_pkg.sv ====
// constants shared by the converter update handshake control block
package duh_pkg;
    // frame layout
    localparam int          FRAME_BITS = 24;                 // bits per serial frame
    localparam int          CNT_W      = 5;                  // falling-edge counter width
    localparam logic [4:0]  LAST_BIT   = 5'h17;              // count at the 24th falling edge
    localparam int          CMD_MSB    = 23;                 // command field top bit
    localparam int          CMD_LSB    = 20;                 // command field bottom bit
    localparam int          VAL_MSB    = 19;                 // value field top bit
    localparam int          VAL_LSB    = 2;                  // value field bottom bit

    // command codes in the frame's top nibble
    localparam logic [3:0]  CMD_DATA   = 4'h1;               // write data input register
    localparam logic [3:0]  CMD_OFFSET = 4'h2;               // write offset input register
    localparam logic [3:0]  CMD_GAIN   = 4'h3;               // write gain input register
    localparam logic [3:0]  CMD_SWRST  = 4'h4;               // software reset

    // code widths and reset values
    localparam int          DATA_W     = 18;                 // converter code width
    localparam logic [17:0] SIGN_BIT   = 18'h20000;          // msb flip for two's complement
    localparam logic [17:0] MIDSCALE   = 18'h20000;          // midscale default code
    localparam logic [17:0] ZEROSCALE  = 18'h00000;          // zero-scale default code
    localparam logic [17:0] GAIN_DEF   = 18'h04000;          // unity gain
    localparam logic [17:0] OFFSET_DEF = 18'h00000;          // no offset
    localparam logic [17:0] CODE_MAX   = 18'h3FFFF;          // top of the code range
    localparam int          GAIN_SHIFT = 14;                 // gain fraction bits

    // timing
    localparam int          CLK_PERIOD_NS = 50;              // sys_clk period
    localparam int          BUSY_TIME_NS  = 4900;            // calculation time
    localparam int          SWRST_TIME_NS = 100;             // software reset length
    localparam logic [7:0]  BUSY_CYCLES   =
        8'((BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0]  SWRST_CYCLES  =
        8'((SWRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // control states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CALC  = 3'b010,
        ST_RESET = 3'b100
    } duh_state_t;
endpackage

// ==== rtl/duh_sync.sv ====
// two flip-flop synchroniser for a group of level inputs
module duh_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstB,
    // levels
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;   // metastable stage, read only by stage two

    // two stages per bit, cleared to zero at reset
    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            stage1  <= '0;
            syncOut <= '0;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule

// ==== rtl/duh_link_rx.sv ====
// serial-clock side: frame counting, capture, ready and data-out enable
module duh_link_rx (
    // reset and link pins
    input  wire logic        rstB,
    input  wire logic        sclk,
    input  wire logic        csB,
    input  wire logic        din,
    // toward the system domain
    output logic [23:0]      frameWord,
    output logic             frameToggle,
    // link outputs
    output logic             readyB,
    output logic             dout,
    output logic             doutOe
);
    logic [duh_pkg::CNT_W-1:0] bitCount;   // falling edges seen in this frame
    logic [23:0]               shiftReg;   // incoming bits, also the chain delay line

    // frame bit counter; chip select high clears it, so an aborted frame is lost
    // abort on early rise
    always_ff @(negedge sclk or posedge csB or negedge rstB) begin
        if (!rstB) begin
            bitCount <= '0;
        end else if (csB) begin
            bitCount <= '0;
        end else if (bitCount == duh_pkg::LAST_BIT) begin
            bitCount <= '0;
        end else begin
            bitCount <= bitCount + 5'h01;
        end
    end

    // sample on each falling edge
    // falling edge sampling
    always_ff @(negedge sclk or negedge rstB) begin
        if (!rstB) begin
            shiftReg <= '0;
        end else begin
            shiftReg <= {shiftReg[22:0], din};
        end
    end

    // whole frame captured; the toggle tells the system domain
    // word stays stable for 24 more edges, far longer than the crossing needs
    // capture at 24th edge
    always_ff @(negedge sclk or negedge rstB) begin
        if (!rstB) begin
            frameWord   <= '0;
            frameToggle <= 1'b0;
        end else if (!csB && bitCount == duh_pkg::LAST_BIT) begin
            frameWord   <= {shiftReg[22:0], din};
            frameToggle <= ~frameToggle;
        end
    end

    // ready falls after the 24th edge, rises with chip select
    // ready low on completion
    always_ff @(negedge sclk or posedge csB or negedge rstB) begin
        if (!rstB) begin
            readyB <= 1'b1;
        end else if (csB) begin
            readyB <= 1'b1;
        end else if (bitCount == duh_pkg::LAST_BIT) begin
            readyB <= 1'b0;
        end
    end

    // data out changes on the rising edge, giving the next device half a period
    always_ff @(posedge sclk or negedge rstB) begin
        if (!rstB) begin
            dout <= 1'b0;
        end else begin
            dout <= shiftReg[23];
        end
    end

    // driven from the chip select fall until the frame ends or aborts
    // enable on select
    assign doutOe = !csB && readyB;
endmodule

// ==== dv/duh_spi_host.sv ====
// spi host model: sends frames msb first on a 12 ns serial clock
module duh_spi_host (
    // link pins toward the device
    output logic sclk,
    output logic csB,
    output logic din,
    // chained data coming back from the device
    input  logic dout
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] got = 24'h000000;   // bits seen on the chained output, one per fall
    // clock stands low and select high between frames
    initial begin
        sclk = 1'b0;
        csB  = 1'b1;
        din  = 1'b0;
    end
    // n bits msb first, device samples on each fall
    task automatic send(input logic [23:0] w, input int n);
        csB = 1'b0;
        #15;
        for (int i = 23; i > 23 - n; i--) begin
            din = w[i];
            #3 sclk = 1'b1;
            #6;
            // taken just before the fall, as a chained next device would
            got = {got[22:0], dout};
            sclk = 1'b0;
            #3;
        end
        // released data line shows the inverse so stale bits never pass
        din = ~din;
    endtask
    // raising select early aborts the frame
    task automatic stop();
        #6 csB = 1'b1;
        #30;
    endtask
endmodule

// ==== dv/dac_update_handshake_control_test.sv ====
// self-checking bench for the converter update handshake control block
module dac_update_handshake_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;           // system clock
    logic        rst_b = 1'b0;             // power-on reset
    logic        hwResetB = 1'b0;          // hardware reset pin
    logic        loadOutputN = 1'b1;       // load pin
    logic        levelSelect = 1'b1;       // default level
    logic        inputFormatSelect = 1'b0; // data format
    logic        extBusy = 1'b0;           // outside logic pulling busy
    logic        sclk, csB, din, dout, doutOe, readyB, busyOut, busyOe, outputClamped;
    logic [17:0] dacCode;                  // converter code
    logic [31:0] rs = 32'd82034;           // xorshift state
    logic [17:0] val;                      // random value
    int          n_errors = 0;
    int          comparisons = 0;
    int          expCode;                  // model code held in the input registers
    int          modelDac;                 // model converter output code
    logic        powerDownIn = 1'b0;       // power-down pin
    logic [23:0] chainExp = 24'h000000;    // model of the chain delay register
    wire         busyIn = !busyOe && !extBusy;
    initial forever #25 sys_clk = ~sys_clk;
    duh_spi_host duh_spi_host_i (.sclk(sclk), .csB(csB), .din(din), .dout(dout));
    duh_top duh_top_i (.sys_clk(sys_clk), .rst_b(rst_b), .sclk(sclk), .csB(csB),
        .din(din), .dout(dout), .doutOe(doutOe), .readyB(readyB), .hwResetB(hwResetB),
        .loadOutputN(loadOutputN), .levelSelect(levelSelect),
        .inputFormatSelect(inputFormatSelect), .powerDownIn(powerDownIn), .busyIn(busyIn),
        .busyOut(busyOut), .busyOe(busyOe), .dacCode(dacCode), .outputClamped(outputClamped));
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // inputs move 2 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic load();
        loadOutputN = 1'b0;
        step(3);
        loadOutputN = 1'b1;
        step(4);
    endtask
    task automatic waitIdle();
        for (int i = 0; i < 300 && busyOe !== 1'b0; i++) step(1);
        check(busyOe, 1'b0);
    endtask
    // busy from a short reset lasts only a few cycles, so poll for it
    task automatic waitBusy();
        for (int i = 0; i < 20 && busyOe !== 1'b1; i++) step(1);
        check(busyOe, 1'b1);
    endtask
    // one frame; a full frame must return the chain delay register contents on the chained output
    task automatic frame(input logic [23:0] w, input int n);
        logic [23:0] prior;
        prior = chainExp;
        duh_spi_host_i.send(w, n);
        if (n == 24) begin
            check(duh_spi_host_i.got, prior);
        end
        chainExp = (chainExp << n) | (w >> (24 - n));
    endtask
    // full data frame; the model stores the code as straight binary
    task automatic write(input logic [17:0] v);
        frame({duh_pkg::CMD_DATA, v, 2'b00}, 24);
        // ready low is what a chained next device takes as its select
        check(readyB, 1'b0);
        check(doutOe, 1'b0);
        duh_spi_host_i.stop();
        check(readyB, 1'b1);
        expCode = inputFormatSelect ? (v ^ duh_pkg::SIGN_BIT) : v;
        step(5);
        check(busyOe, 1'b1);
        check(busyOut, 1'b0);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #500us;
        n_errors++;
        end_of_test();
    end
    initial begin
        step(16);
        check(busyOe, 1'b1);
        rst_b = 1'b1;
        hwResetB = 1'b1;
        step(8);
        modelDac = duh_pkg::MIDSCALE;
        check(dacCode, modelDac);
        // both formats, load held off while busy
        for (int f = 0; f < 2; f++) begin
            inputFormatSelect = f[0];
            step(4);
            val = 18'(rnd());
            write(val);
            val = 18'(rnd());
            write(val);
            load();
            check(dacCode, modelDac);
            waitIdle();
            step(4);
            modelDac = expCode;
            check(dacCode, modelDac);
        end
        $display("format and deferred load test done");
        write(18'(rnd()));
        waitIdle();
        extBusy = 1'b1;
        load();
        check(dacCode, modelDac);
        extBusy = 1'b0;
        step(6);
        modelDac = expCode;
        check(dacCode, modelDac);
        $display("external busy test done");
        // aborted frame
        frame({duh_pkg::CMD_DATA, ~dacCode, 2'b00}, 10);
        check(doutOe, 1'b1);
        duh_spi_host_i.stop();
        check(doutOe, 1'b0);
        check(readyB, 1'b1);
        step(6);
        check(busyOe, 1'b0);
        load();
        modelDac = expCode;
        check(dacCode, modelDac);
        $display("abort test done");
        // software reset reloads the midscale default
        frame({duh_pkg::CMD_SWRST, 20'h00000}, 24);
        duh_spi_host_i.stop();
        waitBusy();
        waitIdle();
        load();
        modelDac = duh_pkg::MIDSCALE;
        expCode = duh_pkg::MIDSCALE;
        check(dacCode, modelDac);
        // hardware reset with zero-scale select, loads ignored meanwhile
        levelSelect = 1'b0;
        hwResetB = 1'b0;
        step(4);
        load();
        check(busyOe, 1'b1);
        hwResetB = 1'b1;
        step(8);
        modelDac = duh_pkg::ZEROSCALE;
        check(dacCode, modelDac);
        // power-down clamps the output but leaves the code alone
        powerDownIn = 1'b1;
        step(4);
        check(outputClamped, 1'b1);
        check(dacCode, modelDac);
        powerDownIn = 1'b0;
        step(4);
        check(outputClamped, 1'b0);
        load();
        check(dacCode, duh_pkg::ZEROSCALE);
        $display("reset test done");
        end_of_test();
    end
endmodule
